//--- cpmd_board.sv
module cpmd_board (
  // Chosen connection of each pin, two bits a pin
  input logic [7:0] tie,
  // Resolved level codes
  output logic [1:0] code0,
  output logic [1:0] code1,
  output logic [1:0] code2,
  output logic [1:0] code3
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ground 0, fast LED net 1, gigabit LED net 2, supply 3
  assign {code3, code2, code1, code0} = tie;
endmodule

//--- cpmd_decode.v
`include "cpmd_regs.vh"
module cpmd_decode (
  // Captured pin level codes
  input wire [1:0] code0,
  input wire [1:0] code1,
  input wire [1:0] code2,
  input wire [1:0] code3,
  // Decoded strap values
  output reg [2:0] addr,
  output reg pause,
  output reg mac_off,
  output reg [4:0] profile
);
  // Pin codes to address, pause, clock and profile
  always @* begin
    addr = {code1[0], code0};
    pause = code1[1];
    mac_off = code3[1];
    profile = `CPMD_P_10HD;
    if (!code3[0]) begin
      profile = {3'h0, code2};
    end else begin
      case (code2)
        2'h0: profile = `CPMD_P_ALL;
        2'h1: profile = `CPMD_P_100AN;
        2'h2: profile = `CPMD_P_ALLSL;
        default: profile = `CPMD_P_ALLMS;
      endcase
    end
  end
endmodule

//--- cpmd_regs.vh
`ifndef CPMD_REGS_VH
`define CPMD_REGS_VH
// Register byte offsets
`define CPMD_OFF_CTRL 8'h00
`define CPMD_OFF_ADV 8'h04
`define CPMD_OFF_GBE 8'h08
`define CPMD_OFF_EXT 8'h0c
`define CPMD_OFF_MODES 8'h10
`define CPMD_OFF_PINS 8'h14
// Control register fields
`define CPMD_CTRL_RESET 15
`define CPMD_CTRL_SPD0 13
`define CPMD_CTRL_ANEN 12
`define CPMD_CTRL_DUP 8
`define CPMD_CTRL_SPD1 6
// Advertisement and extended fields
`define CPMD_ADV_PAUSE 10
`define CPMD_EXT_MACOFF 3
`define CPMD_EXT_PROF_LO 11
// Reset values
`define CPMD_CTRL_RST 16'h1140
`define CPMD_ADV_RST 16'h01e1
`define CPMD_GBE_RST 16'h0300
// Profile codes
`define CPMD_P_10HD 5'h00
`define CPMD_P_10FD 5'h01
`define CPMD_P_100HD 5'h02
`define CPMD_P_100FD 5'h03
`define CPMD_P_100AN 5'h04
`define CPMD_P_ALL 5'h07
`define CPMD_P_ALLSL 5'h09
`define CPMD_P_ALLMS 5'h0a
// Bus answers
`define CPMD_RESP_OK 2'b00
`define CPMD_RESP_ERR 2'b10
`endif

//--- cpmd_top.v
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`include "cpmd_regs.vh"
module cpmd_top (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Configuration pin level codes from the pin detectors
  input wire [1:0] pin_level_code0,
  input wire [1:0] pin_level_code1,
  input wire [1:0] pin_level_code2,
  input wire [1:0] pin_level_code3,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Configuration seen by the rest of the device
  output reg [4:0] phy_address_field,
  output reg mac_clock_off_bit,
  output reg soft_reset_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [7:0] pin_meta;
  reg [7:0] pin_sync;
  always @(posedge mclk) begin
    pin_meta <= {pin_level_code3, pin_level_code2, pin_level_code1, pin_level_code0};
    pin_sync <= pin_meta;
  end

  // Decoder of the synchronised codes
  wire [2:0] dec_addr;
  wire dec_pause;
  wire dec_mac_off;
  wire [4:0] dec_profile;
  cpmd_decode u_dec (
    .code0(pin_sync[1:0]),
    .code1(pin_sync[3:2]),
    .code2(pin_sync[5:4]),
    .code3(pin_sync[7:6]),
    .addr(dec_addr),
    .pause(dec_pause),
    .mac_off(dec_mac_off),
    .profile(dec_profile)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [15:0] ctrl;
  reg [15:0] adv;
  reg [15:0] gbe;
  reg [4:0] profile;
  reg [1:0] rel_cnt;
  reg [7:0] pins_latched;
  reg apply;

  // Bus write handshake state
  reg [7:0] aw_addr;
  reg aw_have;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_have;
  wire do_write = aw_have && w_have && !s_axi_bvalid;
  wire wr_lo = w_strb[0];
  wire wr_hi = w_strb[1];
  wire [15:0] wmask = {{8{wr_hi}}, {8{wr_lo}}};
  wire wr_ctrl = do_write && (aw_addr == `CPMD_OFF_CTRL);
  wire wr_adv = do_write && (aw_addr == `CPMD_OFF_ADV);
  wire wr_gbe = do_write && (aw_addr == `CPMD_OFF_GBE);
  wire wr_ext = do_write && (aw_addr == `CPMD_OFF_EXT);
  wire wr_modes = do_write && (aw_addr == `CPMD_OFF_MODES);
  wire wr_known = wr_ctrl | wr_adv | wr_gbe | wr_ext | wr_modes
    | (do_write && (aw_addr == `CPMD_OFF_PINS));

  // Profile-derived values of the impacted bits
  reg [15:0] d_ctrl;
  reg [15:0] d_adv;
  reg [15:0] d_gbe;
  always @* begin
    d_ctrl = ctrl;
    d_adv = adv;
    d_gbe = gbe;
    d_gbe[9:8] = 2'b00;
    case (profile)
      `CPMD_P_10HD: {d_ctrl[13], d_ctrl[12], d_ctrl[8], d_ctrl[6]} = 4'h0;
      `CPMD_P_10FD: {d_ctrl[13], d_ctrl[12], d_ctrl[8], d_ctrl[6]} = 4'h2;
      `CPMD_P_100HD: {d_ctrl[13], d_ctrl[12], d_ctrl[8], d_ctrl[6]} = 4'h8;
      `CPMD_P_100FD: {d_ctrl[13], d_ctrl[12], d_ctrl[8], d_ctrl[6]} = 4'ha;
      `CPMD_P_100AN: begin
        {d_ctrl[13], d_ctrl[12], d_ctrl[8], d_ctrl[6]} = 4'hc;
        d_adv[8:5] = 4'h4;
      end
      `CPMD_P_ALL, `CPMD_P_ALLSL, `CPMD_P_ALLMS: begin
        {d_ctrl[13], d_ctrl[12], d_ctrl[6]} = 3'h3;
        d_adv[8:5] = 4'hf;
        d_gbe[12:8] = (profile == `CPMD_P_ALL) ? 5'h03 :
          ((profile == `CPMD_P_ALLSL) ? 5'h13 : 5'h1f);
      end
      default: begin
        d_gbe = gbe;
      end
    endcase
  end

  // Strap capture after release, then derived bits; software writes after
  always @(posedge mclk) begin
    if (rst) begin
      ctrl <= `CPMD_CTRL_RST;
      adv <= `CPMD_ADV_RST;
      gbe <= `CPMD_GBE_RST;
      profile <= `CPMD_P_10HD;
      phy_address_field <= 5'h00;
      mac_clock_off_bit <= 1'b0;
      pins_latched <= 8'h00;
      rel_cnt <= 2'h0;
      apply <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= 1'b0;
      apply <= 1'b0;
      if (rel_cnt != 2'h3) begin
        rel_cnt <= rel_cnt + 2'h1;
      end
      if (rel_cnt == 2'h2) begin
        // Pins have passed both synchroniser stages
        pins_latched <= pin_sync;
        phy_address_field <= {2'b00, dec_addr};
        adv[`CPMD_ADV_PAUSE] <= dec_pause;
        mac_clock_off_bit <= dec_mac_off;
        profile <= dec_profile;
        apply <= 1'b1;
      end else if (apply) begin
        ctrl <= d_ctrl;
        adv <= d_adv;
        gbe <= d_gbe;
      end else begin
        if (wr_ctrl) begin
          // Soft reset self-clears and keeps all values
          ctrl <= (w_data[15:0] & wmask & 16'h7fff) | (ctrl & ~wmask);
          soft_reset_pulse <= wr_hi && w_data[`CPMD_CTRL_RESET];
        end
        if (wr_adv) begin
          adv <= (w_data[15:0] & wmask) | (adv & ~wmask);
        end
        if (wr_gbe) begin
          gbe <= (w_data[15:0] & wmask) | (gbe & ~wmask);
        end
        if (wr_ext) begin
          // Profile write stores only; derived bits untouched
          if (wr_hi) begin
            profile <= w_data[15:11];
          end
          if (wr_lo) begin
            mac_clock_off_bit <= w_data[`CPMD_EXT_MACOFF];
          end
        end
        if (wr_modes && wr_lo) begin
          phy_address_field <= w_data[4:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  always @(posedge mclk) begin
    if (rst) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CPMD_RESP_OK;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid && !aw_have && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        aw_have <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_have && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `CPMD_RESP_OK : `CPMD_RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  always @(posedge mclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CPMD_RESP_OK;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CPMD_RESP_OK;
        case (ra)
          `CPMD_OFF_CTRL: s_axi_rdata <= {16'h0000, ctrl};
          `CPMD_OFF_ADV: s_axi_rdata <= {16'h0000, adv};
          `CPMD_OFF_GBE: s_axi_rdata <= {16'h0000, gbe};
          `CPMD_OFF_EXT: s_axi_rdata <= {16'h0000, profile, 7'h00, mac_clock_off_bit, 3'h0};
          `CPMD_OFF_MODES: s_axi_rdata <= {27'h0000000, phy_address_field};
          `CPMD_OFF_PINS: s_axi_rdata <= {24'h000000, pins_latched};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CPMD_RESP_ERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

//--- cpmd_top_asserts.sv
module cpmd_top_asserts (
  // Clock and reset
  input logic mclk,
  input logic rst,
  // Pin level codes
  input logic [1:0] pin_level_code0,
  input logic [1:0] pin_level_code1,
  input logic [1:0] pin_level_code2,
  input logic [1:0] pin_level_code3,
  // Bus handshakes
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // Configuration outputs
  input logic [4:0] phy_address_field,
  input logic mac_clock_off_bit,
  input logic soft_reset_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [7:0] pv = {pin_level_code3, pin_level_code2, pin_level_code1, pin_level_code0};
  logic [3:0] cnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Cycles since reset release, saturating
  always @(posedge mclk) begin
    if (rst) cnt <= 4'h0;
    else if (cnt != 4'hf) cnt <= cnt + 4'h1;
  end
  // Release with pins held steady
  sequence rel_s;
    $fell(rst) ##0 $stable(pv)[*6];
  endsequence
  strap_addr_a: assert property (rel_s |-> phy_address_field == {2'b00, pv[2:0]})
    else $error("strapped address wrong");
  mac_strap_a: assert property (rel_s |-> mac_clock_off_bit == pin_level_code3[1])
    else $error("strapped clock off bit wrong");
  addr_range_a: assert property (cnt == 4'h8 |-> phy_address_field[4:3] == 2'b00)
    else $error("strapped address above seven");
  strap_hold_a: assert property ($changed({phy_address_field, mac_clock_off_bit}) &&
    cnt > 4'h6 |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("outputs moved unasked");
  soft_keep_a: assert property (soft_reset_pulse |=>
    $stable({phy_address_field, mac_clock_off_bit})[*4]) else $error("soft reset reloaded");
  soft_pulse_a: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
  b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
endmodule
bind cpmd_top cpmd_top_asserts u_chk (.mclk, .rst, .pin_level_code0, .pin_level_code1,
  .pin_level_code2, .pin_level_code3, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
  .s_axi_rready, .phy_address_field, .mac_clock_off_bit, .soft_reset_pulse);

//--- testbench.sv
`include "cpmd_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] tie = 8'h00;
  logic [1:0] c0, c1, c2, c3;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [4:0] phy_address_field, p, np;
  logic mac_clock_off_bit, soft_reset_pulse;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int errors = 0, checks = 0;
  logic [31:0] seed = 32'h2b80db25;
  logic [7:0] pv;
  logic [31:0] ea, eg;
  ////////////////////////////////////////////////////////////////////////////////
  // Board strapping and block
  cpmd_board u_cpmd_board (.tie, .code0(c0), .code1(c1), .code2(c2), .code3(c3));
  cpmd_top u_cpmd_top (.mclk, .rst, .pin_level_code0(c0), .pin_level_code1(c1),
    .pin_level_code2(c2), .pin_level_code3(c3), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .phy_address_field,
    .mac_clock_off_bit, .soft_reset_pulse);
  // Clock
  initial forever #50 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and hang cut-off
  task automatic final_report();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tmo();
    errors++;
    final_report();
  endtask
  // Comparisons of answers
  task automatic cmp_rd(input logic [33:0] e);
    checks++;
    if ({s_axi_rresp, s_axi_rdata} !== e) begin
      errors++;
      $display("MISMATCH %0t read %h exp %h", $time, {s_axi_rresp, s_axi_rdata}, e);
    end
  endtask
  task automatic cmp_wr(input logic [1:0] e);
    checks++;
    if (s_axi_bresp !== e) begin
      errors++;
      $display("MISMATCH %0t bresp %b exp %b", $time, s_axi_bresp, e);
    end
  endtask
  // Oldest note against each answer
  always @(posedge mclk) begin
    if (s_axi_rvalid === 1'b1) cmp_rd(rq.pop_front());
    if (s_axi_bvalid === 1'b1) cmp_wr(bq.pop_front());
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Bus cycles, each channel held until taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] r = `CPMD_RESP_OK);
    int n = 0;
    @(posedge mclk);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    if (n >= 40) tmo();
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r = `CPMD_RESP_OK);
    int n = 0;
    @(posedge mclk);
    rq.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    if (n >= 40) tmo();
  endtask
  // Hardware reset with new strapping
  task automatic hw_reset(input logic [7:0] t);
    @(posedge mclk);
    tie <= t;
    rst <= 1'b1;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    repeat (7) @(posedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Expected values
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [4:0] prof(input logic [3:0] c);
    logic [4:0] hi [4] = '{5'h07, 5'h04, 5'h09, 5'h0a};
    return c[2] ? hi[c[1:0]] : {3'b000, c[1:0]};
  endfunction
  function automatic logic [15:0] ctl(input logic [4:0] q);
    case (q)
      5'h00: return 16'h0000;
      5'h01: return 16'h0100;
      5'h02: return 16'h2000;
      5'h03: return 16'h2100;
      5'h04: return 16'h3000;
      default: return 16'h1140;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Every pin 3 and pin 2 pair, random pins 1 and 0
  initial begin
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      pv = {i[3:0], seed[3:0]};
      hw_reset(pv);
      tie <= ~pv;
      p = prof(pv[7:4]);
      np = (p == 5'h04) ? 5'h00 : 5'h04;
      ea = {16'h0, 5'h0, pv[3], ((p == 5'h04) ? 10'h081 : 10'h1e1)};
      eg = (p < 5'h05) ? 32'h0 : (p == 5'h07) ? 32'h0300 : (p == 5'h09) ? 32'h1300 : 32'h1f00;
      axi_rd(8'h00, {16'h0, ctl(p)});
      axi_rd(8'h04, ea);
      axi_rd(8'h08, eg);
      axi_rd(8'h0c, {16'h0, p, 7'h0, pv[7], 3'h0});
      axi_rd(8'h10, {29'h0, pv[2:0]});
      axi_wr(8'h0c, {16'h0, np, 7'h0, pv[7], 3'h0}, 4'h3);
      axi_wr(8'h00, {16'h0, 16'h8000 | ctl(p)}, 4'h3);
      axi_rd(8'h00, {16'h0, ctl(p)});
      axi_rd(8'h04, ea);
      axi_rd(8'h08, eg);
      axi_rd(8'h0c, {16'h0, np, 7'h0, pv[7], 3'h0});
      axi_wr(8'h10, {27'h0, 1'b1, i[3:0]}, 4'h1);
      axi_rd(8'h10, {27'h0, 1'b1, i[3:0]});
      axi_wr(8'h14, 32'h0, 4'hf);
      axi_rd(8'h18, 32'h0, `CPMD_RESP_ERR);
      axi_wr(8'h18, 32'hffff, 4'hf, `CPMD_RESP_ERR);
      axi_rd(8'h14, {24'h0, pv});
    end
    final_report();
  end
endmodule
